//--- charge_setpoint_limiter.sv
// charge setpoint limiter: strap decode, voltage clamp, delta-sigma current DAC,
// input FET and mains detect supervision, APB register access
// assumes all comparator inputs are synchronous to clk_sys_i
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module charge_setpoint_limiter
  import csl_pkg::*;
#(
  parameter int unsigned BURST_BIT_CYCLES = BURST_BIT_CYC,
  parameter int unsigned STRAP_STABLE     = STRAP_STABLE_CYC
) (
  input  wire logic        clk_sys_i,                 // system clock
  input  wire logic        rst_b_i,                   // async reset, active low
  input  wire logic        psel_i,                    // apb select
  input  wire logic        penable_i,                 // apb enable
  input  wire logic        pwrite_i,                  // apb direction
  input  wire logic [7:0]  paddr_i,                   // apb byte address
  input  wire logic [31:0] pwdata_i,                  // apb write data
  output logic      [31:0] prdata_o,                  // apb read data
  output logic             pready_o,                  // apb ready
  output logic             pslverr_o,                 // apb error
  input  wire logic [7:0]  voltage_ceiling_pin_i,     // strap comparators
  input  wire logic [5:0]  current_ceiling_pin_i,     // strap comparators
  input  wire logic        adapter_above_130mv_i,     // input minus sense > 130mV
  input  wire logic        adapter_above_25mv_i,      // input minus sense > 25mV
  input  wire logic        adapter_above_neg25mv_i,   // input minus sense > -25mV
  input  wire logic        adapter_sense_hi_i,        // above mains threshold
  input  wire logic        adapter_sense_lo_i,        // above threshold minus hyst
  input  wire logic        input_current_over_i,      // input sense > 100mV
  input  wire logic        charger_active_pin_i,      // pin level
  output logic             charger_active_pin_o,      // pin drive value
  output logic             charger_active_pin_oe_o,   // pin drive enable
  output logic             mains_detect_output_o,     // mains present
  output logic             input_fet_slow_off_o,      // slow gate turn-off
  output logic             input_fet_fast_off_o,      // fast gate turn-off
  output logic             current_set_resistor_o,    // current DAC switch
  output logic [10:0]      voltage_dac_o              // 16mV codes above reference
);

  function automatic logic [3:0] vstrap_dec(input logic [7:0] c);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 0; k < 5; k++) begin
      if (c == VSTRAP_PAT[k]) r = {1'b1, 3'(k)};
    end
    return r;
  endfunction : vstrap_dec

  function automatic logic [2:0] istrap_dec(input logic [5:0] c);
    logic [2:0] r;
    r = 3'h0;
    for (int k = 0; k < 4; k++) begin
      if (c == ISTRAP_PAT[k]) r = {1'b1, 2'(k)};
    end
    return r;
  endfunction : istrap_dec

  // apb
  logic        acc_phase;
  logic        wr_en;
  logic [31:0] rd_nxt;
  logic        err_nxt;
  csl_ctrl_t   ctrl_r;
  logic [15:0] vreq_r;
  logic [15:0] ireq_r;
  csl_status_t stat;

  // straps
  logic [7:0]  vstrap_s_r;
  logic [5:0]  istrap_s_r;
  logic [7:0]  vstrap_prev_r;
  logic [5:0]  istrap_prev_r;
  logic [15:0] strap_cnt_r;
  logic [2:0]  vceil_code_r;
  logic [1:0]  iceil_code_r;
  logic [3:0]  vdec;
  logic [2:0]  idec;

  // voltage
  logic [15:0] vceil_mv;
  logic [15:0] vclamp;
  logic [15:0] vdiff;
  logic        vor_r;

  // supply supervision
  logic        chg_en_r;
  logic        mains_r;
  logic        charge_ok;

  // current dac
  logic [15:0] ifs;
  logic [15:0] ireq_eff;
  logic [15:0] ds_num;
  logic [16:0] ds_sum;
  logic [16:0] ds_acc_r;
  logic        ds_bit_r;
  logic        burst;
  logic        burst_r;
  logic [2:0]  pwm_cnt_r;
  logic [31:0] slow_cnt_r;
  logic        ds_step;

  assign acc_phase = psel_i & penable_i & pready_o;
  assign wr_en     = acc_phase & pwrite_i & ~pslverr_o;

  always_comb begin
    stat.iceil_code             = iceil_code_r;
    stat.vceil_code             = vceil_code_r;
    stat.adapter_limit          = input_current_over_i;
    stat.low_current_burst_mode = burst_r;
    stat.mains_detected_flag    = mains_r;
    stat.input_supply_low_flag  = ~chg_en_r;
    stat.voltage_over_range     = vor_r;
  end

  always_comb begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    case (paddr_i)
      ADDR_CTRL:   rd_nxt = {30'h0, ctrl_r};
      ADDR_VREQ:   rd_nxt = {16'h0000, vreq_r};
      ADDR_IREQ:   rd_nxt = {16'h0000, ireq_r};
      ADDR_STATUS: rd_nxt = {22'h0, stat};
      ADDR_VDAC:   rd_nxt = {21'h0, voltage_dac_o};
      default:     err_nxt = 1'b1;
    endcase
  end

  // read data and error are captured in the setup cycle, so access is one cycle long
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & err_nxt;
      prdata_o  <= (psel_i & ~penable_i & ~pwrite_i) ? rd_nxt : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r <= '0;
      vreq_r <= VREQ_RST;
      ireq_r <= IREQ_RST;
    end else if (wr_en) begin
      if (paddr_i == ADDR_CTRL) ctrl_r <= csl_ctrl_t'(pwdata_i[1:0]);
      if (paddr_i == ADDR_VREQ) vreq_r <= pwdata_i[15:0];
      if (paddr_i == ADDR_IREQ) ireq_r <= pwdata_i[15:0];
    end
  end

  // strap decoding: sample, then accept only a pattern that held steady
  assign vdec = vstrap_dec(vstrap_s_r);
  assign idec = istrap_dec(istrap_s_r);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vstrap_s_r    <= 8'h00;
      istrap_s_r    <= 6'h00;
      vstrap_prev_r <= 8'h00;
      istrap_prev_r <= 6'h00;
      strap_cnt_r   <= 16'h0000;
    end else begin
      vstrap_s_r    <= voltage_ceiling_pin_i;
      istrap_s_r    <= current_ceiling_pin_i;
      vstrap_prev_r <= vstrap_s_r;
      istrap_prev_r <= istrap_s_r;
      if (vstrap_s_r != vstrap_prev_r || istrap_s_r != istrap_prev_r ||
          !vdec[3] || !idec[2]) begin
        strap_cnt_r <= 16'h0000;
      end else if (strap_cnt_r != 16'(STRAP_STABLE)) begin
        strap_cnt_r <= strap_cnt_r + 16'h0001;
      end
    end
  end

  // reset leaves the lowest ceilings in force until a steady reading arrives
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vceil_code_r <= 3'h0;
      iceil_code_r <= 2'h0;
    end else if (strap_cnt_r == 16'(STRAP_STABLE) && vdec[3] && idec[2]) begin
      vceil_code_r <= vdec[2:0];
      iceil_code_r <= idec[1:0];
    end
  end

  // voltage path
  assign vceil_mv = VCEIL_MV[vceil_code_r];
  assign vclamp   = (vreq_r > vceil_mv) ? vceil_mv : vreq_r;
  assign vdiff    = vclamp - VREF_MV;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      voltage_dac_o <= 11'h000;
      vor_r         <= 1'b0;
    end else begin
      vor_r <= vreq_r > vceil_mv;
      if (vreq_r < VREF_MV) begin
        voltage_dac_o <= 11'h000;
      end else begin
        voltage_dac_o <= 11'(vdiff >> VSTEP_SHIFT);
      end
    end
  end

  // input FET and charger enable: 130mV to start, -25mV hard stop
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chg_en_r             <= 1'b0;
      input_fet_slow_off_o <= 1'b1;
      input_fet_fast_off_o <= 1'b1;
    end else begin
      if (!adapter_above_neg25mv_i) begin
        chg_en_r <= 1'b0;
      end else if (adapter_above_130mv_i) begin
        chg_en_r <= 1'b1;
      end
      input_fet_slow_off_o <= ~adapter_above_25mv_i;
      input_fet_fast_off_o <= ~adapter_above_neg25mv_i;
    end
  end

  // pin is driven low while disabled, otherwise released to its pull-up
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      charger_active_pin_o    <= 1'b0;
      charger_active_pin_oe_o <= 1'b1;
    end else begin
      charger_active_pin_o    <= 1'b0;
      charger_active_pin_oe_o <= ~chg_en_r | ~adapter_above_neg25mv_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mains_r               <= 1'b0;
      mains_detect_output_o <= 1'b0;
    end else begin
      if (adapter_sense_hi_i) begin
        mains_r               <= 1'b1;
        mains_detect_output_o <= 1'b1;
      end else if (!adapter_sense_lo_i) begin
        mains_r               <= 1'b0;
        mains_detect_output_o <= 1'b0;
      end
    end
  end

  // external pulldown only pauses; stored requests stay and resume on release
  assign charge_ok = chg_en_r & charger_active_pin_i;

  // current DAC
  assign ifs      = IFS_MA[iceil_code_r];
  assign ireq_eff = ctrl_r.wake_up ? WAKE_MA :
                    (ireq_r > ifs) ? ifs : ireq_r;
  assign burst    = ~ctrl_r.burst_mode_disable &
                    ({ireq_eff, 4'h0} < {4'h0, ifs});
  // each burst pulse carries one eighth of full scale, so density scales by eight
  assign ds_num   = burst ? {ireq_eff[12:0], 3'h0} : ireq_eff;
  assign ds_sum   = ds_acc_r + {1'b0, ds_num};
  assign ds_step  = ~burst_r | (slow_cnt_r == 32'h0000_0000);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      burst_r    <= 1'b0;
      pwm_cnt_r  <= 3'h0;
      slow_cnt_r <= 32'h0000_0000;
    end else begin
      burst_r   <= burst;
      pwm_cnt_r <= pwm_cnt_r + 3'h1;
      if (!burst_r || slow_cnt_r == 32'(BURST_BIT_CYCLES - 1)) begin
        slow_cnt_r <= 32'h0000_0000;
      end else begin
        slow_cnt_r <= slow_cnt_r + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ds_acc_r <= 17'h00000;
      ds_bit_r <= 1'b0;
    end else if (ds_step) begin
      if (ds_sum >= {1'b0, ifs}) begin
        ds_acc_r <= ds_sum - {1'b0, ifs};
        ds_bit_r <= 1'b1;
      end else begin
        ds_acc_r <= ds_sum;
        ds_bit_r <= 1'b0;
      end
    end
  end

  // adapter limit takes precedence over the programmed current
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      current_set_resistor_o <= 1'b0;
    end else if (!charge_ok || input_current_over_i) begin
      current_set_resistor_o <= 1'b0;
    end else if (burst) begin
      current_set_resistor_o <= ds_bit_r & (pwm_cnt_r == 3'h0);
    end else begin
      current_set_resistor_o <= ds_bit_r;
    end
  end

endmodule : charge_setpoint_limiter
`default_nettype wire

//--- csl_chk.sv
// port checker for the charge setpoint limiter
// assumes comparator levels already sit in the clk_sys_i domain
`timescale 1ns/1ps
`default_nettype none
module csl_chk (
  input wire logic        clk_sys_i,               // clock
  input wire logic        rst_b_i,                 // reset
  input wire logic        adapter_above_130mv_i,   // headroom
  input wire logic        adapter_above_25mv_i,    // forward
  input wire logic        adapter_above_neg25mv_i, // reverse
  input wire logic        adapter_sense_hi_i,      // mains on
  input wire logic        adapter_sense_lo_i,      // mains hold
  input wire logic        input_current_over_i,    // limit
  input wire logic        charger_active_pin_i,    // wire
  input wire logic        charger_active_pin_o,    // drive value
  input wire logic        charger_active_pin_oe_o, // pull
  input wire logic        mains_detect_output_o,   // mains
  input wire logic        input_fet_slow_off_o,    // slow
  input wire logic        input_fet_fast_off_o,    // fast
  input wire logic        current_set_resistor_o,  // dac bit
  input wire logic [10:0] voltage_dac_o            // code
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  // three cycles, so a headroom pulse that already set the enable is not flagged
  sequence s_blocked;
    (!adapter_above_130mv_i && charger_active_pin_oe_o) [*3];
  endsequence
  sequence s_reverse;
    !adapter_above_neg25mv_i;
  endsequence
  hold_low_a:
    assert property (s_blocked |=> charger_active_pin_oe_o)
    else $error("pin released without headroom");
  fast_off_a:
    assert property (s_reverse |=> input_fet_fast_off_o && charger_active_pin_oe_o)
    else $error("no fast off on reverse");
  slow_off_a:
    assert property (!adapter_above_25mv_i |=> input_fet_slow_off_o)
    else $error("no slow off");
  mains_set_a:
    assert property (adapter_sense_hi_i |=> mains_detect_output_o)
    else $error("mains not set");
  mains_clr_a:
    assert property (!adapter_sense_lo_i |=> !mains_detect_output_o)
    else $error("mains not cleared");
  mains_hold_a:
    assert property (adapter_sense_lo_i && !adapter_sense_hi_i |=> $stable(mains_detect_output_o))
    else $error("mains moved in band");
  dac_gate_a:
    assert property (current_set_resistor_o |-> $past(charger_active_pin_i)
                     && !$past(input_current_over_i))
    else $error("dac on while gated");
  pin_drive_a:
    assert property (charger_active_pin_oe_o |-> !charger_active_pin_o)
    else $error("pin driven high while enabled");
  vdac_max_a:
    assert property (voltage_dac_o <= 11'h113)
    else $error("voltage code above top ceiling");
endmodule : csl_chk
bind charge_setpoint_limiter csl_chk csl_chk_inst (.*);
`default_nettype wire

//--- csl_far_model.sv
// far side: strap dividers, adapter comparators, charger-active wire
// assumes the bench picks strap codes and adapter conditions
`timescale 1ns/1ps
`default_nettype none
module csl_far_model
  import csl_pkg::*;
(
  input  wire logic [2:0] vcode_i, // voltage strap 0..4
  input  wire logic [1:0] icode_i, // current strap
  input  wire logic [2:0] diff_i,  // 0 <-25 1 <25 2 <130 3 above
  input  wire logic [1:0] slvl_i,  // 0 low 1 band 2 high
  input  wire logic       ext_i,   // outside party pulls low
  input  wire logic       oe_i,    // device pulls low
  output logic      [7:0] vpin_o,  // voltage comparators
  output logic      [5:0] ipin_o,  // current comparators
  output logic            a130_o,  // above 130mV
  output logic            a25_o,   // above 25mV
  output logic            an25_o,  // above -25mV
  output logic            shi_o,   // above threshold
  output logic            slo_o,   // above threshold less hysteresis
  output logic            pin_o    // wire level
);
  assign vpin_o = VSTRAP_PAT[vcode_i];
  assign ipin_o = ISTRAP_PAT[icode_i];
  assign a130_o = diff_i >= 3'h3;
  assign a25_o  = diff_i >= 3'h2;
  assign an25_o = diff_i >= 3'h1;
  assign shi_o  = slvl_i == 2'h2;
  assign slo_o  = slvl_i != 2'h0;
  // pull-up on the wire; either party may hold it low
  assign pin_o  = !(oe_i | ext_i);
endmodule : csl_far_model
`default_nettype wire

//--- csl_pkg.sv
// constants, field layouts and carrier types for the charge setpoint limiter
// assumes a 100 MHz system clock and comparator outputs already in that domain
// Notes on behaviour
// - voltage strap decodes into five codes
// - strap fixes voltage ceiling, software cannot exceed
// - subtract reference offset before voltage DAC
// - request below reference programs zero output
// - over-ceiling request clamps, sets over-range flag
// - requests between reference and 2.9V accepted
// - current DAC density is request over full-scale
// - below one sixteenth full scale enters burst
// - burst pulses at one-eighth duty, gated
// - burst modulator advances about every 45ms
// - burst average current equals request
// - burst disable bit blocks burst mode
// - wake-up holds modulator at 80mA
// - charger enabled only when input above sense
// - needs 130mV headroom, pin held low until
// - below 25mV input FET turns off slowly
// - below -25mV fast off, pin low, disabled
// - adapter sense high sets mains detect
// - mains detect clears below hysteresis threshold
// - input sense over 100mV overrides charge current
// - current strap selects one of four maxima
// - external pin pulldown pauses, release resumes values
package csl_pkg;

  localparam int unsigned CLK_KHZ         = 100_000;
  localparam int unsigned BURST_BIT_MS    = 45;
  localparam int unsigned BURST_BIT_CYC   = BURST_BIT_MS * CLK_KHZ;
  localparam int unsigned STRAP_STABLE_CYC = 16;

  localparam logic [15:0] VREF_MV         = 16'h0450;  // 1104 mV
  localparam logic [15:0] VMIN_OK_MV      = 16'h0B54;  // 2900 mV
  localparam logic [15:0] VSTEP_SHIFT     = 16'h0004;  // 16 mV per code
  localparam logic [15:0] WAKE_MA         = 16'h0050;  // 80 mA

  localparam logic [15:0] VCEIL_MV [5] = '{16'h1090, 16'h10D0, 16'h1150, 16'h11A0, 16'h1580};
  localparam logic [15:0] IFS_MA   [4] = '{16'h03FF, 16'h07FE, 16'h0BFC, 16'h0FFC};

  // thermometer patterns of the strap comparators, lowest threshold in bit 0
  localparam logic [7:0] VSTRAP_PAT [5] = '{8'h00, 8'h03, 8'h0F, 8'h3F, 8'hFF};
  localparam logic [5:0] ISTRAP_PAT [4] = '{6'h00, 6'h03, 6'h0F, 6'h3F};

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_VREQ   = 8'h04;
  localparam logic [7:0] ADDR_IREQ   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_VDAC   = 8'h10;

  localparam int unsigned CTRL_BURST_DIS_BIT = 0;
  localparam int unsigned CTRL_WAKE_BIT      = 1;
  localparam logic [15:0] VREQ_RST = 16'h0000;
  localparam logic [15:0] IREQ_RST = 16'h0000;

  typedef struct packed {
    logic wake_up;
    logic burst_mode_disable;
  } csl_ctrl_t;

  typedef struct packed {
    logic [1:0] iceil_code;
    logic [2:0] vceil_code;
    logic       adapter_limit;
    logic       low_current_burst_mode;
    logic       mains_detected_flag;
    logic       input_supply_low_flag;
    logic       voltage_over_range;
  } csl_status_t;

endpackage : csl_pkg

//--- tb.sv
// self-checking bench for the charge setpoint limiter
// assumes csl_far_model stands for the charger loop and straps
`timescale 1ns/1ps
`default_nettype none
module tb;
  import csl_pkg::*;
  logic        clk_sys_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0]  paddr_i, voltage_ceiling_pin_i;
  logic [31:0] pwdata_i, prdata_o, r;
  logic [5:0]  current_ceiling_pin_i;
  logic [10:0] voltage_dac_o;
  logic        adapter_above_130mv_i, adapter_above_25mv_i, adapter_above_neg25mv_i;
  logic        adapter_sense_hi_i, adapter_sense_lo_i, input_current_over_i;
  logic        charger_active_pin_i, charger_active_pin_oe_o, mains_detect_output_o;
  logic        input_fet_slow_off_o, input_fet_fast_off_o, current_set_resistor_o;
  logic [2:0]  vcode, diff;
  logic [1:0]  icode, slvl;
  logic        ext, perr;
  logic [15:0] vs [6];
  logic [11:0] tab [5] = '{12'h17E, 12'h4AE, 12'h68C, 12'h210, 12'h70C};
  int          n_fail, cmp_count, fs;
  charge_setpoint_limiter #(.BURST_BIT_CYCLES(40), .STRAP_STABLE(4))
    charge_setpoint_limiter_inst (.charger_active_pin_o(), .*);
  csl_far_model csl_far_model_inst (.vcode_i(vcode), .icode_i(icode), .diff_i(diff),
    .slvl_i(slvl), .ext_i(ext), .oe_i(charger_active_pin_oe_o),
    .vpin_o(voltage_ceiling_pin_i), .ipin_o(current_ceiling_pin_i),
    .a130_o(adapter_above_130mv_i), .a25_o(adapter_above_25mv_i),
    .an25_o(adapter_above_neg25mv_i), .shi_o(adapter_sense_hi_i),
    .slo_o(adapter_sense_lo_i), .pin_o(charger_active_pin_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // the tests need about 50k cycles; a hang is cut off well inside the run budget
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    n_fail++;
    print_verdict();
  end
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol = 0);
    cmp_count++;
    if (tol == 0 ? got !== exp :
        ($isunknown(got) || got > exp + tol || got + tol < exp)) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one idle cycle after each transfer keeps two drives of psel out of one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    r = prdata_o;
    perr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : apb
  task automatic dens(input int req);
    int c;
    c = 0;
    repeat (4) @(posedge clk_sys_i);
    repeat (8192) begin
      @(posedge clk_sys_i);
      c += current_set_resistor_o;
    end
    chk(c, 8192 * req / fs, req ? 16 : 0);
  endtask : dens
  function automatic logic [31:0] vexp(input logic [15:0] v, input int c);
    logic [15:0] m;
    m = (v > VCEIL_MV[c]) ? VCEIL_MV[c] : v;
    return (v < VREF_MV) ? 32'h0 : 32'((m - VREF_MV) >> 4);
  endfunction : vexp
  initial begin
    void'($urandom(16));
    {rst_b_i, psel_i, penable_i, pwrite_i, input_current_over_i, ext} <= 6'h00;
    {paddr_i, pwdata_i} <= 40'h0;
    {vcode, icode, diff, slvl} <= 10'h13A;
    repeat (8) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    for (int a = 0; a < 3; a++) begin
      apb(1'b0, 8'(a * 4), 32'h0);
      chk(r, 32'h0);
    end
    apb(1'b1, ADDR_CTRL, 32'hFFFFFFFF);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(r, 32'h3);
    apb(1'b1, 8'h14, 32'h5);
    chk(perr, 1'b1);
    $display("registers done");
    for (int c = 0; c < 5; c++) begin
      vcode <= 3'(c);
      repeat (12) @(posedge clk_sys_i);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(r[7:5], c);
      vs = '{16'($urandom_range(1103)), VREF_MV, 16'($urandom_range(2899, 1104)),
             VCEIL_MV[c], VCEIL_MV[c] + 16'h1, 16'($urandom_range(65535, 1104))};
      foreach (vs[k]) begin
        apb(1'b1, ADDR_VREQ, 32'(vs[k]));
        // the dac code is launched on the edge the task ends on, so look one edge later
        @(posedge clk_sys_i);
        chk(voltage_dac_o, vexp(vs[k], c));
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(r[0], vs[k] > VCEIL_MV[c]);
      end
    end
    $display("voltage done");
    for (int c = 0; c < 4; c++) begin
      icode <= 2'(c);
      fs = IFS_MA[c];
      repeat (12) @(posedge clk_sys_i);
      for (int k = 0; k < 3; k++) begin
        apb(1'b1, ADDR_CTRL, 32'(k == 2));
        // full scales are not multiples of 16: the first non-burst value rounds up
        apb(1'b1, ADDR_IREQ, 32'((fs + 15) / 16 - (k == 1 ? 0 : 1)));
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(r[9:8], c);
        chk(r[3], k == 0);
      end
    end
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_IREQ, 32'h7D0);
    dens(2000);
    input_current_over_i <= 1'b1;
    dens(0);
    input_current_over_i <= 1'b0;
    ext <= 1'b1;
    dens(0);
    ext <= 1'b0;
    dens(2000);
    apb(1'b1, ADDR_IREQ, 32'hC8);
    dens(200);
    apb(1'b1, ADDR_CTRL, 32'h2);
    apb(1'b1, ADDR_IREQ, 32'h0);
    dens(80);
    $display("current done");
    foreach (tab[i]) begin
      diff <= tab[i][11:9];
      slvl <= tab[i][8:7];
      repeat (3) @(posedge clk_sys_i);
      chk({input_fet_fast_off_o, charger_active_pin_oe_o, input_fet_slow_off_o,
           mains_detect_output_o}, tab[i][6:3]);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(r[2:1], tab[i][2:1]);
    end
    $display("supply done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
